// [oag_consts.vh]
// Constants for the operand address generator
`ifndef OAG_CONSTS_VH
`define OAG_CONSTS_VH
`define OAG_MODE_REG      3'h0
`define OAG_MODE_WREG     3'h1
`define OAG_MODE_PTR      3'h2
`define OAG_MODE_IDX      3'h3
`define OAG_MODE_ABS      3'h4
`define OAG_MODE_PCREL    3'h5
`define OAG_MODE_LIT      3'h6
`define OAG_OP_LOAD       3'h0
`define OAG_OP_LOADPM     3'h1
`define OAG_OP_LOADEXT    3'h2
`define OAG_OP_JABS       3'h3
`define OAG_OP_CALL       3'h4
`define OAG_OP_JREL       3'h5
`define OAG_OP_ALU        3'h6
`define OAG_WREG_BASE     8'hC0
`define OAG_ST_IDLE       2'h0
`define OAG_ST_RD1        2'h1
`define OAG_ST_RD2        2'h2
`define OAG_ST_DONE       2'h3
`endif

// [oag_operand_address_generator.v]
// Operand effective-address generator for an 8-bit core
// Contract
// (RULE_01) Six addressing modes; each instruction accepts only its own subset. The code decodes seven, with working-register mode on its own.
// (RULE_02) Register mode: operand is contents of the named register.
// (RULE_03) Working-register mode: 4-bit number indexes 16-byte working area.
// (RULE_04) Pointer mode: register or pair contents is the operand address.
// (RULE_05) Any 8-bit register may point into the register file.
// (RULE_06) Any 16-bit pair may point into program or external memory.
// (RULE_07) Register-file index: instruction base plus working-register offset.
// (RULE_08) Memory index: pair base plus 8- or 16-bit instruction offset.
// (RULE_09) Short memory offset is sign-extended, -128 to +127.
// (RULE_10) Only plain load may use indexed register-file addressing.
// (RULE_11) Program and external loads support indexed memory addressing.
// (RULE_12) Absolute mode: 16-bit address; jump and call load it into PC.
// (RULE_13) Program and external loads may use absolute source or destination.
// (RULE_14) Relative mode: signed displacement added to PC gives next address.
// (RULE_15) PC already advanced past current instruction before the addition.
// (RULE_16) Only relative jump accepts PC-relative addressing.
// (RULE_17) Literal mode: operand field is the operand, no lookup.
// (RULE_18) Working area maps to register-file C0H through CFH.
// (RULE_19) Pairs start at even address; high byte even, low byte odd.
// (RULE_20) Indexed register-file address keeps low eight bits only.
`include "oag_consts.vh"
`default_nettype none
module oag_operand_address_generator (
    input  wire        clk,
    input  wire        srst,
    input  wire        start,
    input  wire [2:0]  mode,
    input  wire [2:0]  opcode,
    input  wire [7:0]  reg_field,
    input  wire [15:0] imm_field,
    input  wire        long_offset,
    input  wire        pair_sel,
    input  wire        mem_dest,
    input  wire [15:0] next_pc_in,
    input  wire [7:0]  rf_rdata,
    output wire [7:0]  rf_raddr,
    output wire        rf_rd,
    output reg         done,
    output reg         mode_error,
    output reg  [7:0]  operand,
    output reg         operand_valid,
    output reg  [7:0]  rf_addr,
    output reg         rf_addr_valid,
    output reg  [15:0] mem_addr,
    output reg         mem_addr_valid,
    output reg         mem_is_program,
    output reg         mem_write,
    output reg  [15:0] pc_target,
    output reg         pc_load,
    output wire        busy
);
    reg [1:0]  state;
    reg [7:0]  rd_addr;
    reg [7:0]  first_byte;
    reg [2:0]  cur_mode;
    reg [2:0]  cur_op;
    reg [7:0]  cur_reg;
    reg [15:0] cur_imm;
    reg        cur_long;
    reg        cur_pair;
    reg        cur_dest;
    reg [1:0]  next_state;
    reg [7:0]  next_rd_addr;

    // Working register number to register-file address
    function [7:0] wreg_addr;
        input [3:0] num;
        begin
            wreg_addr = `OAG_WREG_BASE | {4'h0, num}; // see (RULE_03) see (RULE_18)
        end
    endfunction

    // Operation is an absolute jump or a call to a new program address; relative jump is not included
    function is_jump;
        input [2:0] op;
        begin
            is_jump = (op == `OAG_OP_JABS) || (op == `OAG_OP_CALL);
        end
    endfunction

    // Operation loads from program or external memory
    function is_mem_load;
        input [2:0] op;
        begin
            is_mem_load = (op == `OAG_OP_LOADPM) || (op == `OAG_OP_LOADEXT);
        end
    endfunction

    // Eight-bit two's-complement displacement to sixteen bits
    function [15:0] sext8;
        input [7:0] v;
        begin
            sext8 = {{8{v[7]}}, v};
        end
    endfunction

    // Pairs always start at the even address
    function [7:0] pair_addr;
        input [7:0] r;
        begin
            pair_addr = {r[7:1], 1'b0}; // see (RULE_19)
        end
    endfunction

    // Mode legality per instruction
    function legal;
        input [2:0] m;
        input [2:0] op;
        begin
            case (m)
                `OAG_MODE_REG, `OAG_MODE_WREG, `OAG_MODE_LIT:
                    legal = (op == `OAG_OP_LOAD) || (op == `OAG_OP_ALU);
                `OAG_MODE_PTR:
                    legal = (op != `OAG_OP_JREL) && (op != `OAG_OP_CALL);
                `OAG_MODE_IDX:
                    legal = (op == `OAG_OP_LOAD) || (op == `OAG_OP_LOADPM)
                            || (op == `OAG_OP_LOADEXT); // see (RULE_10) see (RULE_11)
                `OAG_MODE_ABS:
                    legal = (op == `OAG_OP_JABS) || (op == `OAG_OP_CALL)
                            || (op == `OAG_OP_LOADPM) || (op == `OAG_OP_LOADEXT); // see (RULE_12) see (RULE_13)
                `OAG_MODE_PCREL:
                    legal = (op == `OAG_OP_JREL); // see (RULE_16)
                default:
                    legal = 1'b0;
            endcase
        end
    endfunction

    wire        is_mem_op = is_mem_load(cur_op) || is_jump(cur_op);
    wire [15:0] short_off = sext8(cur_imm[7:0]); // see (RULE_09)
    wire [15:0] idx_off   = cur_long ? cur_imm : short_off; // see (RULE_08)
    wire [7:0]  rf_sum    = cur_imm[7:0] + rf_rdata; // see (RULE_07) see (RULE_20)

    assign rf_raddr = rd_addr;
    assign rf_rd    = (state == `OAG_ST_RD1) || (state == `OAG_ST_RD2);
    assign busy     = (state != `OAG_ST_IDLE);

    // Sequencer: one-cycle modes and refusals never leave idle
    always @* begin
        next_state = state;
        case (state)
            `OAG_ST_IDLE: begin
                if (start && legal(mode, opcode)) begin
                    case (mode)
                        `OAG_MODE_LIT, `OAG_MODE_ABS, `OAG_MODE_PCREL: begin
                            next_state = `OAG_ST_IDLE;
                        end
                        default: begin
                            next_state = `OAG_ST_RD1;
                        end
                    endcase
                end
            end
            `OAG_ST_RD1: begin
                case (cur_mode)
                    `OAG_MODE_REG, `OAG_MODE_WREG: begin
                        next_state = `OAG_ST_IDLE;
                    end
                    `OAG_MODE_IDX: begin
                        // Register-file form is done after the offset read
                        if (cur_op == `OAG_OP_LOAD) begin
                            next_state = `OAG_ST_IDLE;
                        end else begin
                            next_state = `OAG_ST_RD2;
                        end
                    end
                    default: begin
                        if (is_mem_op || cur_pair) begin
                            next_state = `OAG_ST_RD2;
                        end else begin
                            next_state = `OAG_ST_IDLE;
                        end
                    end
                endcase
            end
            `OAG_ST_RD2: begin
                next_state = `OAG_ST_IDLE;
            end
            default: begin
                next_state = `OAG_ST_IDLE;
            end
        endcase
    end

    // Register-file read address for the coming cycle
    always @* begin
        next_rd_addr = rd_addr;
        case (state)
            `OAG_ST_IDLE: begin
                case (mode)
                    `OAG_MODE_WREG: begin
                        next_rd_addr = wreg_addr(reg_field[3:0]); // see (RULE_03)
                    end
                    `OAG_MODE_IDX: begin
                        // Register-file form reads the offset, memory form the pair
                        if (opcode == `OAG_OP_LOAD) begin
                            next_rd_addr = wreg_addr(reg_field[3:0]); // see (RULE_07)
                        end else begin
                            next_rd_addr = wreg_addr({reg_field[3:1], 1'b0}); // see (RULE_08) see (RULE_19)
                        end
                    end
                    `OAG_MODE_PTR: begin
                        if (pair_sel || is_mem_load(opcode) || (opcode == `OAG_OP_JABS)) begin
                            next_rd_addr = pair_addr(reg_field); // see (RULE_06)
                        end else begin
                            next_rd_addr = reg_field; // see (RULE_05)
                        end
                    end
                    default: begin
                        next_rd_addr = reg_field; // see (RULE_02)
                    end
                endcase
            end
            `OAG_ST_RD1: begin
                // Low byte of a pair sits at the odd address
                next_rd_addr = rd_addr | 8'h01; // see (RULE_19)
            end
            default: begin
                next_rd_addr = rd_addr;
            end
        endcase
    end

    always @(posedge clk) begin
        if (srst) begin
            state          <= `OAG_ST_IDLE;
            rd_addr        <= 8'h00;
            first_byte     <= 8'h00;
            cur_mode       <= 3'h0;
            cur_op         <= 3'h0;
            cur_reg        <= 8'h00;
            cur_imm        <= 16'h0000;
            cur_long       <= 1'b0;
            cur_pair       <= 1'b0;
            cur_dest       <= 1'b0;
            done           <= 1'b0;
            mode_error     <= 1'b0;
            operand        <= 8'h00;
            operand_valid  <= 1'b0;
            rf_addr        <= 8'h00;
            rf_addr_valid  <= 1'b0;
            mem_addr       <= 16'h0000;
            mem_addr_valid <= 1'b0;
            mem_is_program <= 1'b0;
            mem_write      <= 1'b0;
            pc_target      <= 16'h0000;
            pc_load        <= 1'b0;
        end else begin
            done           <= 1'b0;
            mode_error     <= 1'b0;
            operand_valid  <= 1'b0;
            rf_addr_valid  <= 1'b0;
            mem_addr_valid <= 1'b0;
            pc_load        <= 1'b0;
            state          <= next_state;
            rd_addr        <= next_rd_addr;
            case (state)
                `OAG_ST_IDLE: begin
                    if (start) begin
                        cur_mode <= mode;
                        cur_op   <= opcode;
                        cur_reg  <= reg_field;
                        cur_imm  <= imm_field;
                        cur_long <= long_offset;
                        cur_pair <= pair_sel;
                        cur_dest <= mem_dest;
                        mem_is_program <= (opcode == `OAG_OP_LOADPM);
                        mem_write <= mem_dest;
                        if (!legal(mode, opcode)) begin // see (RULE_01)
                            mode_error <= 1'b1;
                            done       <= 1'b1;
                        end else begin
                            case (mode)
                                `OAG_MODE_LIT: begin
                                    operand       <= imm_field[7:0]; // see (RULE_17)
                                    operand_valid <= 1'b1;
                                    done          <= 1'b1;
                                end
                                `OAG_MODE_ABS: begin
                                    if (is_jump(opcode)) begin
                                        pc_target <= imm_field; // see (RULE_12)
                                        pc_load   <= 1'b1;
                                    end else begin
                                        mem_addr       <= imm_field; // see (RULE_13)
                                        mem_addr_valid <= 1'b1;
                                    end
                                    done <= 1'b1;
                                end
                                `OAG_MODE_PCREL: begin
                                    // PC input already points past this instruction
                                    pc_target <= next_pc_in + sext8(imm_field[7:0]); // see (RULE_14) see (RULE_15)
                                    pc_load   <= 1'b1;
                                    done      <= 1'b1;
                                end
                                default: begin
                                    // Register reads start in the next cycle
                                end
                            endcase
                        end
                    end
                end
                `OAG_ST_RD1: begin
                    first_byte <= rf_rdata;
                    case (cur_mode)
                        `OAG_MODE_REG, `OAG_MODE_WREG: begin
                            operand       <= rf_rdata; // see (RULE_02)
                            operand_valid <= 1'b1;
                            rf_addr       <= rd_addr;
                            rf_addr_valid <= 1'b1;
                            done          <= 1'b1;
                        end
                        `OAG_MODE_IDX: begin
                            if (cur_op == `OAG_OP_LOAD) begin
                                rf_addr       <= rf_sum; // see (RULE_07) see (RULE_20)
                                rf_addr_valid <= 1'b1;
                                done          <= 1'b1;
                            end
                        end
                        default: begin
                            if (!(is_mem_op || cur_pair)) begin
                                rf_addr       <= rf_rdata; // see (RULE_04) see (RULE_05)
                                rf_addr_valid <= 1'b1;
                                done          <= 1'b1;
                            end
                        end
                    endcase
                end
                `OAG_ST_RD2: begin
                    // High byte was at even address, low byte arrives now
                    if (cur_mode == `OAG_MODE_IDX) begin
                        mem_addr       <= {first_byte, rf_rdata} + idx_off; // see (RULE_08) see (RULE_11)
                        mem_addr_valid <= 1'b1;
                    end else if (cur_op == `OAG_OP_JABS) begin
                        pc_target <= {first_byte, rf_rdata}; // see (RULE_06)
                        pc_load   <= 1'b1;
                    end else begin
                        mem_addr       <= {first_byte, rf_rdata}; // see (RULE_04) see (RULE_06) see (RULE_19)
                        mem_addr_valid <= 1'b1;
                    end
                    mem_write <= cur_dest;
                    done      <= 1'b1;
                end
                default: begin
                    first_byte <= 8'h00;
                end
            endcase
        end
    end
endmodule // oag_operand_address_generator
`default_nettype wire

// [oag_operand_address_generator_assertions.sv]
// Assertion checker for the operand address generator
`include "oag_consts.vh"
`default_nettype none
module oag_checker (
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        start,
    input wire logic        busy,
    input wire logic [2:0]  mode,
    input wire logic [2:0]  opcode,
    input wire logic [7:0]  reg_field,
    input wire logic [15:0] imm_field,
    input wire logic [15:0] next_pc_in,
    input wire logic        done,
    input wire logic        mode_error,
    input wire logic [7:0]  operand,
    input wire logic        operand_valid,
    input wire logic [7:0]  rf_raddr,
    input wire logic        rf_rd,
    input wire logic [15:0] pc_target,
    input wire logic        pc_load,
    input wire logic        mem_addr_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    logic take;
    assign take = start && !busy;
    property p_lit; take && mode == `OAG_MODE_LIT && opcode == `OAG_OP_LOAD
        |=> done && operand_valid && operand == $past(imm_field[7:0]); endproperty
    a_lit: assert property (p_lit) else $error("literal operand wrong");
    property p_reg; take && mode == `OAG_MODE_REG && opcode == `OAG_OP_LOAD |=> busy && !done ##1 done && operand_valid;
    endproperty
    a_reg: assert property (p_reg) else $error("register read timing wrong");
    property p_wreg; take && mode == `OAG_MODE_WREG && (opcode == `OAG_OP_LOAD || opcode == `OAG_OP_ALU)
        |=> rf_rd && rf_raddr == (`OAG_WREG_BASE | {4'h0, $past(reg_field[3:0])}); endproperty
    a_wreg: assert property (p_wreg) else $error("working register address wrong");
    property p_pair; take && mode == `OAG_MODE_PTR && opcode == `OAG_OP_LOADPM
        |=> rf_rd && !rf_raddr[0] ##1 rf_rd && rf_raddr[0] ##1 done && mem_addr_valid; endproperty
    a_pair: assert property (p_pair) else $error("pair read order wrong");
    property p_rel; take && mode == `OAG_MODE_PCREL && opcode == `OAG_OP_JREL
        |=> pc_load && pc_target == $past(next_pc_in) + {{8{$past(imm_field[7])}}, $past(imm_field[7:0])}; endproperty
    a_rel: assert property (p_rel) else $error("relative target wrong");
    property p_jabs; take && mode == `OAG_MODE_ABS && opcode == `OAG_OP_JABS |=> pc_load && pc_target == $past(imm_field);
    endproperty
    a_jabs: assert property (p_jabs) else $error("absolute jump target wrong");
    property p_relonly; take && mode == `OAG_MODE_PCREL && opcode != `OAG_OP_JREL |=> done && mode_error && !pc_load;
    endproperty
    a_relonly: assert property (p_relonly) else $error("relative mode not refused");
    property p_idxalu; take && mode == `OAG_MODE_IDX && opcode == `OAG_OP_ALU |=> done && mode_error && !operand_valid;
    endproperty
    a_idxalu: assert property (p_idxalu) else $error("indexed alu not refused");
    property p_err; mode_error |-> done && !pc_load && !mem_addr_valid && !operand_valid; endproperty
    a_err: assert property (p_err) else $error("refusal carries a result");
endmodule // oag_checker
bind oag_operand_address_generator oag_checker u_oag_checker (.clk(clk), .srst(srst), .start(start), .busy(busy),
    .mode(mode), .opcode(opcode), .reg_field(reg_field), .imm_field(imm_field), .next_pc_in(next_pc_in),
    .done(done), .mode_error(mode_error), .operand(operand), .operand_valid(operand_valid), .rf_raddr(rf_raddr),
    .rf_rd(rf_rd), .pc_target(pc_target), .pc_load(pc_load), .mem_addr_valid(mem_addr_valid));
`default_nettype wire

// [tb_oag_operand_address_generator.sv]
// Self-checking testbench for the operand address generator
`include "oag_consts.vh"
`default_nettype none
module tb_oag_operand_address_generator;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        start = 1'b0;
    logic [2:0]  mode = 3'h0;
    logic [2:0]  opcode = 3'h0;
    logic [7:0]  reg_field = 8'h00;
    logic [15:0] imm_field = 16'h0000;
    logic        long_offset = 1'b0;
    logic        pair_sel = 1'b0;
    logic        mem_dest = 1'b0;
    logic [15:0] next_pc_in = 16'h0000;
    logic [7:0]  rf_rdata, rf_raddr, operand, rf_addr;
    logic [15:0] mem_addr, pc_target;
    logic        rf_rd, done, mode_error, operand_valid, rf_addr_valid;
    logic        mem_addr_valid, mem_is_program, mem_write, pc_load, busy;
    int          bad_count = 0;
    int          check_count = 0;
    function automatic logic [7:0] rf_val(input logic [7:0] a);
        return {a[3:0], a[7:4]} ^ 8'h3C;
    endfunction
    always #5 clk = ~clk;
    // Register file model answers in the same cycle
    assign rf_rdata = rf_val(rf_raddr);
    oag_operand_address_generator u_oag_operand_address_generator (.clk(clk), .srst(srst), .start(start),
        .mode(mode), .opcode(opcode), .reg_field(reg_field), .imm_field(imm_field), .long_offset(long_offset),
        .pair_sel(pair_sel), .mem_dest(mem_dest), .next_pc_in(next_pc_in), .rf_rdata(rf_rdata),
        .rf_raddr(rf_raddr), .rf_rd(rf_rd), .done(done), .mode_error(mode_error), .operand(operand),
        .operand_valid(operand_valid), .rf_addr(rf_addr), .rf_addr_valid(rf_addr_valid), .mem_addr(mem_addr),
        .mem_addr_valid(mem_addr_valid), .mem_is_program(mem_is_program), .mem_write(mem_write),
        .pc_target(pc_target), .pc_load(pc_load), .busy(busy));
    task automatic report_and_stop;
        if (bad_count == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic cmp(input logic [19:0] got, input logic [19:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One request, then wait for done; returns inside the done cycle
    task automatic xfer(input logic [2:0] m, input logic [2:0] op, input logic [7:0] r, input logic [15:0] imm,
                        input logic [2:0] flags, input int lat);
        int n;
        @(posedge clk);
        start <= 1'b1;
        {mode, opcode, reg_field, imm_field, long_offset, pair_sel, mem_dest} <= {m, op, r, imm, flags};
        @(posedge clk);
        start <= 1'b0;
        n = 1;
        #1;
        while (done !== 1'b1 && n < 6) begin
            @(posedge clk);
            #1;
            n++;
        end
        cmp(20'(n), 20'(lat));
    endtask
    task automatic t_direct;
        xfer(`OAG_MODE_LIT, `OAG_OP_LOAD, 8'h00, 16'h12A5, 3'b000, 1);
        cmp({operand_valid, operand}, {1'b1, 8'hA5});
        xfer(`OAG_MODE_REG, `OAG_OP_LOAD, 8'h47, 16'h0000, 3'b000, 2);
        cmp({operand_valid, operand}, {1'b1, rf_val(8'h47)});
        xfer(`OAG_MODE_WREG, `OAG_OP_ALU, 8'hFB, 16'h0000, 3'b000, 2);
        cmp({operand_valid, operand}, {1'b1, rf_val(8'hCB)});
    endtask
    task automatic t_pointer;
        xfer(`OAG_MODE_PTR, `OAG_OP_LOAD, 8'h30, 16'h0000, 3'b000, 2);
        cmp({rf_addr_valid, rf_addr}, {1'b1, rf_val(8'h30)});
        xfer(`OAG_MODE_PTR, `OAG_OP_LOADPM, 8'h20, 16'h0000, 3'b010, 3);
        cmp({mem_addr_valid, mem_is_program, mem_addr}, {2'b11, rf_val(8'h20), rf_val(8'h21)});
    endtask
    task automatic t_indexed;
        xfer(`OAG_MODE_IDX, `OAG_OP_LOAD, 8'h05, 16'h00F0, 3'b000, 2);
        cmp({rf_addr_valid, rf_addr}, {1'b1, rf_val(8'hC5) + 8'hF0});
        xfer(`OAG_MODE_IDX, `OAG_OP_LOADEXT, 8'h03, 16'h0080, 3'b000, 3);
        cmp({mem_addr_valid, mem_is_program, mem_addr}, {2'b10, {rf_val(8'hC2), rf_val(8'hC3)} + 16'hFF80});
        xfer(`OAG_MODE_IDX, `OAG_OP_LOADPM, 8'h04, 16'h1234, 3'b100, 3);
        cmp({mem_addr_valid, mem_is_program, mem_addr}, {2'b11, {rf_val(8'hC4), rf_val(8'hC5)} + 16'h1234});
    endtask
    task automatic t_absolute;
        xfer(`OAG_MODE_ABS, `OAG_OP_JABS, 8'h00, 16'hBEEF, 3'b000, 1);
        cmp({pc_load, pc_target}, {1'b1, 16'hBEEF});
        xfer(`OAG_MODE_ABS, `OAG_OP_CALL, 8'h00, 16'h0102, 3'b000, 1);
        cmp({pc_load, pc_target}, {1'b1, 16'h0102});
        xfer(`OAG_MODE_ABS, `OAG_OP_LOADEXT, 8'h00, 16'h8001, 3'b001, 1);
        cmp({mem_addr_valid, mem_write, mem_is_program, mem_addr}, {3'b110, 16'h8001});
        xfer(`OAG_MODE_ABS, `OAG_OP_LOADPM, 8'h00, 16'h7FFE, 3'b000, 1);
        cmp({mem_addr_valid, mem_write, mem_is_program, mem_addr}, {3'b101, 16'h7FFE});
    endtask
    task automatic t_relative;
        @(posedge clk);
        next_pc_in <= 16'h0FF0;
        xfer(`OAG_MODE_PCREL, `OAG_OP_JREL, 8'h00, 16'h0080, 3'b000, 1);
        cmp({pc_load, pc_target}, {1'b1, 16'h0F70});
        xfer(`OAG_MODE_PCREL, `OAG_OP_JREL, 8'h00, 16'h007F, 3'b000, 1);
        cmp({pc_load, pc_target}, {1'b1, 16'h106F});
    endtask
    task automatic t_refuse;
        logic [5:0] combo [4] = '{{`OAG_MODE_IDX, `OAG_OP_ALU}, {`OAG_MODE_PCREL, `OAG_OP_JABS},
                                  {`OAG_MODE_PCREL, `OAG_OP_CALL}, {3'h7, `OAG_OP_LOAD}};
        for (int i = 0; i < 4; i++) begin
            xfer(combo[i][5:3], combo[i][2:0], 8'h10, 16'h0000, 3'b000, 1);
            cmp({mode_error, operand_valid, rf_addr_valid, mem_addr_valid, pc_load}, 5'b10000);
        end
    endtask
    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        t_direct;
        t_pointer;
        t_indexed;
        t_absolute;
        t_relative;
        t_refuse;
        report_and_stop;
    end
    initial begin
        repeat (3000) @(posedge clk);
        bad_count++;
        report_and_stop;
    end
endmodule // tb_oag_operand_address_generator
`default_nettype wire
